// ==== src/uph_port.sv ====
// Eight-bit upper I/O port with memory address and PWM overrides
`timescale 1ns/10ps
`default_nettype none
`include "uph_defs.svh"

module uph_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	input wire logic [3:0] mem_addr_hi,
	input wire logic pwm_three_channel_c,
	input wire logic pwm_three_channel_b,
	input wire logic pwm_one_channel_c,
	input wire logic pwm_one_channel_b,
	input wire logic [3:0] pwm_chan_en,
	input wire logic pwm_shutdown,
	output logic [3:0] analog_en
);

	uph_pkg::uph_state_t st;
	uph_pkg::uph_state_t next_st;
	logic [7:0] pin_sync;
	logic [3:0] pwm_val;

	// ----------------------------------------
	// Pin input path
	// ----------------------------------------
	uph_pin_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(pin_in),
		.pin_sync(pin_sync)
	);

	assign pwm_val = {pwm_one_channel_b, pwm_one_channel_c,
		pwm_three_channel_b, pwm_three_channel_c};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [3:0] an_sel;
		logic [3:0] an_now;
		logic mem_on;
		next_st = st;
		an_sel = '0;
		an_now = '0;
		mem_on = !st.bus_dis;

		// Higher channels need a lower select code, so a single field
		// gives a growing run of analog pins
		for (int k = 0; k < 4; k++) begin
			an_sel[k] = (st.acfg[`UPH_ACFG_PCFG_MSB:0] <= 4'(3 - k));
		end
		an_now = an_sel & st.dir[7:4];
		next_st.analog_en = an_now;

		// Register writes
		if (wr_en) begin
			if (addr == `UPH_ADDR_DIR) begin
				next_st.dir = wr_data;
			end else if (addr == `UPH_ADDR_PIN || addr == `UPH_ADDR_LAT) begin
				next_st.lat = wr_data;
			end else if (addr == `UPH_ADDR_ACFG) begin
				next_st.acfg = wr_data[`UPH_ACFG_MSB:0];
			end else if (addr == `UPH_ADDR_CTRL) begin
				next_st.bus_dis = wr_data[`UPH_CTRL_BUS_DIS_BIT];
				next_st.map_sel = wr_data[`UPH_CTRL_MAP_SEL_BIT];
				next_st.sd_tri = wr_data[`UPH_CTRL_SD_TRI_BIT];
			end
		end

		// Register reads, answer in the next cycle only
		next_st.rd_data = 8'h00;
		if (rd_en) begin
			if (addr == `UPH_ADDR_DIR) begin
				next_st.rd_data = st.dir;
			end else if (addr == `UPH_ADDR_PIN) begin
				next_st.rd_data = pin_sync & ~{an_now, 4'h0};
			end else if (addr == `UPH_ADDR_LAT) begin
				next_st.rd_data = st.lat;
			end else if (addr == `UPH_ADDR_ACFG) begin
				next_st.rd_data = {2'h0, st.acfg};
			end else if (addr == `UPH_ADDR_CTRL) begin
				next_st.rd_data = {st.bus_dis, 5'h00, st.sd_tri, st.map_sel};
			end
		end

		// Low pins: address lines win over latch and direction
		for (int i = 0; i < 4; i++) begin
			if (mem_on) begin
				next_st.pin_out[i] = mem_addr_hi[i];
				next_st.pin_oe[i] = 1'b1;
			end else begin
				next_st.pin_out[i] = st.lat[i];
				next_st.pin_oe[i] = !st.dir[i];
			end
		end

		// High pins: PWM wins over latch only on the default map, with map_sel clear
		for (int i = 4; i < 8; i++) begin
			if (st.dir[i]) begin
				next_st.pin_out[i] = st.lat[i];
				next_st.pin_oe[i] = 1'b0;
			end else if (!st.map_sel && pwm_chan_en[i - 4]) begin
				next_st.pin_out[i] = pwm_val[i - 4];
				next_st.pin_oe[i] = !(pwm_shutdown && st.sd_tri);
			end else begin
				next_st.pin_out[i] = st.lat[i];
				next_st.pin_oe[i] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.dir <= `UPH_DIR_RST;
			st.lat <= `UPH_LAT_RST;
			st.acfg <= `UPH_ACFG_RST;
			st.bus_dis <= `UPH_BUS_DIS_RST;
			st.map_sel <= `UPH_MAP_SEL_RST;
			st.sd_tri <= `UPH_SD_TRI_RST;
			st.pin_out <= 8'h00;
			st.pin_oe <= 8'h00;
			st.analog_en <= `UPH_ANALOG_RST;
			st.rd_data <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd_data;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;
	assign analog_en = st.analog_en;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_input_hiz;
		st.dir[7] |=> !pin_oe[7];
	endproperty
	a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");

	property p_latch_drive;
		st.bus_dis && !st.dir[2] |=> pin_oe[2] && pin_out[2] == $past(st.lat[2]);
	endproperty
	a_latch_drive: assert property (p_latch_drive) else $error("latch not driven");

	property p_indep_dir;
		st.bus_dis && st.dir[1] && !st.dir[0] |=> pin_oe[1:0] == 2'b01;
	endproperty
	a_indep_dir: assert property (p_indep_dir) else $error("direction bits coupled");

	property p_latch_read;
		wr_en && addr == `UPH_ADDR_LAT ##1 rd_en && addr == `UPH_ADDR_LAT
			|=> rd_data == $past(wr_data, 2);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch readback wrong");

	property p_pin_read;
		rd_en && addr == `UPH_ADDR_PIN && st.acfg[3:0] == 4'hf
			|=> rd_data == $past(pin_sync);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin readback wrong");

	property p_reset_dir;
		disable iff (1'b0) !rst_n |=> st.dir == 8'hff && pin_oe == 8'h00;
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("reset not input");

	property p_analog_default;
		disable iff (1'b0) !rst_n ##1 rst_n && !wr_en |=> analog_en == 4'hf;
	endproperty
	a_analog_default: assert property (p_analog_default) else $error("analog default lost");

	property p_mem_addr;
		!st.bus_dis |=> pin_oe[3:0] == 4'hf && pin_out[3:0] == $past(mem_addr_hi);
	endproperty
	a_mem_addr: assert property (p_mem_addr) else $error("address override lost");

	property p_pwm_out;
		!st.dir[6] && !st.map_sel && pwm_chan_en[2] && !pwm_shutdown
			|=> pin_oe[6] && pin_out[6] == $past(pwm_one_channel_c);
	endproperty
	a_pwm_out: assert property (p_pwm_out) else $error("pwm not on pin");

	property p_pwm_shutdown;
		!st.dir[4] && !st.map_sel && pwm_chan_en[0] && pwm_shutdown && st.sd_tri
			|=> !pin_oe[4];
	endproperty
	a_pwm_shutdown: assert property (p_pwm_shutdown) else $error("shutdown not hiz");

	property p_pwm_map;
		!st.dir[5] && st.map_sel |=> pin_out[5] == $past(st.lat[5]);
	endproperty
	a_pwm_map: assert property (p_pwm_map) else $error("pwm on wrong map");

	property p_analog_read;
		rd_en && addr == `UPH_ADDR_PIN && st.dir[7:4] == 4'hf && st.acfg[3:0] == 4'h0
			|=> rd_data[7:4] == 4'h0;
	endproperty
	a_analog_read: assert property (p_analog_read) else $error("analog reads nonzero");

	// ----------------------------------------
	// Register bus checks
	// ----------------------------------------
	property p_dir_wr;
		wr_en && addr == `UPH_ADDR_DIR |=> st.dir == $past(wr_data);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");

	property p_dir_rd;
		rd_en && addr == `UPH_ADDR_DIR |=> rd_data == $past(st.dir);
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("direction readback wrong");

	property p_lat_wr;
		wr_en && (addr == `UPH_ADDR_LAT || addr == `UPH_ADDR_PIN) |=> st.lat == $past(wr_data);
	endproperty
	a_lat_wr: assert property (p_lat_wr) else $error("latch write lost");

	// Unmapped addresses must leave dir, lat, acfg and bus_dis alone
	property p_bad_wr;
		wr_en && addr > `UPH_ADDR_CTRL
			|=> $stable(st.dir) && $stable(st.lat) && $stable(st.acfg) && $stable(st.bus_dis);
	endproperty
	a_bad_wr: assert property (p_bad_wr) else $error("unmapped write landed");

	property p_bad_rd;
		rd_en && addr > `UPH_ADDR_CTRL |=> rd_data == 8'h00;
	endproperty
	a_bad_rd: assert property (p_bad_rd) else $error("unmapped read nonzero");

	// Read data stands one cycle only, so an idle bus reads zero
	property p_rd_idle;
		!rd_en |=> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data lingers");

	property p_ctrl_rd;
		rd_en && addr == `UPH_ADDR_CTRL
			|=> rd_data[6:2] == 5'h00 && rd_data[7] == $past(st.bus_dis);
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

	property p_acfg_rd;
		rd_en && addr == `UPH_ADDR_ACFG |=> rd_data[7:6] == 2'h0;
	endproperty
	a_acfg_rd: assert property (p_acfg_rd) else $error("config top bits set");

	// ----------------------------------------
	// Pin override checks
	// ----------------------------------------
	property p_mem_force;
		!st.bus_dis && st.dir[3:0] == 4'hf |=> pin_oe[3:0] == 4'hf;
	endproperty
	a_mem_force: assert property (p_mem_force) else $error("pins not forced");

	property p_low_hiz;
		st.bus_dis && st.dir[0] |=> !pin_oe[0];
	endproperty
	a_low_hiz: assert property (p_low_hiz) else $error("pin 0 driven");

	property p_high_latch;
		!st.dir[7] && (st.map_sel || !pwm_chan_en[3])
			|=> pin_oe[7] && pin_out[7] == $past(st.lat[7]);
	endproperty
	a_high_latch: assert property (p_high_latch) else $error("latch not on pin 7");

	property p_pwm_order;
		!st.dir[5] && !st.map_sel && pwm_chan_en[1] && !pwm_shutdown
			|=> pin_oe[5] && pin_out[5] == $past(pwm_three_channel_b);
	endproperty
	a_pwm_order: assert property (p_pwm_order) else $error("pwm order wrong");

	// Without the tristate enable a shutdown leaves the pin driven
	property p_sd_off;
		!st.dir[7] && !st.map_sel && pwm_chan_en[3] && pwm_shutdown && !st.sd_tri
			|=> pin_oe[7];
	endproperty
	a_sd_off: assert property (p_sd_off) else $error("pin 7 tristated");

	property p_map_low;
		!st.dir[4] && st.map_sel |=> pin_oe[4] && pin_out[4] == $past(st.lat[4]);
	endproperty
	a_map_low: assert property (p_map_low) else $error("pwm off map");

	// ----------------------------------------
	// Analog checks
	// ----------------------------------------
	property p_an_read4;
		rd_en && addr == `UPH_ADDR_PIN && st.dir[4] && st.acfg[3:0] <= 4'h3
			|=> !rd_data[4];
	endproperty
	a_an_read4: assert property (p_an_read4) else $error("pin 4 reads one");

	property p_an_sel2;
		st.acfg[3:0] == 4'h2 && st.dir[7:4] == 4'hf |=> analog_en == 4'h3;
	endproperty
	a_an_sel2: assert property (p_an_sel2) else $error("select 2 wrong");

	property p_an_none;
		st.acfg[3:0] >= 4'h4 |=> analog_en == 4'h0;
	endproperty
	a_an_none: assert property (p_an_none) else $error("analog with none selected");

	// Analog needs the input direction, whatever the select field says
	property p_an_dir;
		!st.dir[4] |=> !analog_en[0];
	endproperty
	a_an_dir: assert property (p_an_dir) else $error("analog on output pin");

	property p_acfg_wr;
		wr_en && addr == `UPH_ADDR_ACFG |=> st.acfg == $past(wr_data[5:0]);
	endproperty
	a_acfg_wr: assert property (p_acfg_wr) else $error("config write lost");

	property p_reset_out;
		disable iff (1'b0) !rst_n
			|=> pin_out == 8'h00 && rd_data == 8'h00 && analog_en == 4'hf;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");

	// ----------------------------------------
	// Covers
	// ----------------------------------------
	c_mem_on: cover property (!st.bus_dis ##1 pin_oe[3:0] == 4'hf);
	c_pwm_drive: cover property (!st.map_sel && !st.dir[7] && pwm_chan_en[3] ##1 pin_oe[7]);
	c_rmw: cover property (rd_en && addr == `UPH_ADDR_LAT ##1 wr_en && addr == `UPH_ADDR_LAT);
	c_sd_tri: cover property (pwm_shutdown && st.sd_tri && !st.dir[4] ##1 !pin_oe[4]);
	c_wr_rd: cover property (wr_en && addr == `UPH_ADDR_LAT ##1 rd_en && addr == `UPH_ADDR_LAT);

endmodule

`default_nettype wire

// ==== shared/uph_defs.svh ====
// Offsets, field positions and reset values for the upper I/O port
`ifndef UPH_DEFS_SVH
`define UPH_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UPH_ADDR_DIR 3'h0
`define UPH_ADDR_PIN 3'h1
`define UPH_ADDR_LAT 3'h2
`define UPH_ADDR_ACFG 3'h3
`define UPH_ADDR_CTRL 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UPH_CTRL_MAP_SEL_BIT 0
`define UPH_CTRL_SD_TRI_BIT 1
`define UPH_CTRL_BUS_DIS_BIT 7
`define UPH_ACFG_PCFG_MSB 3
`define UPH_ACFG_MSB 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UPH_DIR_RST 8'hff
`define UPH_LAT_RST 8'h00
`define UPH_ACFG_RST 6'h00
`define UPH_BUS_DIS_RST 1'b1
`define UPH_MAP_SEL_RST 1'b0
`define UPH_SD_TRI_RST 1'b0
`define UPH_ANALOG_RST 4'hf

`endif

// ==== shared/uph_pkg.sv ====
// Types shared by the upper I/O port modules
package uph_pkg;

	// ----------------------------------------
	// Synchroniser state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] stage1;
		logic [7:0] stage2;
	} uph_sync_t;

	// ----------------------------------------
	// Port state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] lat;
		logic [5:0] acfg;
		logic bus_dis;
		logic map_sel;
		logic sd_tri;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
		logic [3:0] analog_en;
		logic [7:0] rd_data;
	} uph_state_t;

endpackage

// ==== src/uph_pin_sync.sv ====
// Two-stage synchroniser for the eight pin inputs
`timescale 1ns/10ps
`default_nettype none

module uph_pin_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_sync
);

	uph_pkg::uph_sync_t st;
	uph_pkg::uph_sync_t next_st;

	// ----------------------------------------
	// Per-bit stages
	// ----------------------------------------
	// First stage feeds only the second stage
	always_comb begin
		next_st.stage1 = pin_in;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin_sync = st.stage2;

endmodule

`default_nettype wire

// ==== dv/uph_pad_model.sv ====
// Pad model joining the port drivers to the external sources
`timescale 1ns/10ps
`default_nettype none

module uph_pad_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_drv,
	output logic [7:0] pin_in
);
	// ----------------------------------------
	// Wire level
	// ----------------------------------------
	// Driven pins see their own level, so read-back of outputs is real
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule
`default_nettype wire

// ==== dv/test_uph_port.sv ====
// Self-checking testbench for the upper I/O port
`timescale 1ns/10ps
`default_nettype none

module test_uph_port;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data, pin_out, pin_oe, pin_in;
	logic [7:0] ext = 8'h3c;
	logic [3:0] mem_hi = 4'h9;
	logic [3:0] pwm_en = 4'h0;
	// Only one channel high, so any swap that moves it shows
	logic [3:0] pwm = 4'h1;
	logic pwm_sd = 1'b0;
	logic [3:0] analog_en;
	int err_count = 0;
	int samples_checked = 0;

	always #5 clk = ~clk;

	uph_port i_uph_port (
		.clk(clk),
		.rst_n(rst_n),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.mem_addr_hi(mem_hi),
		.pwm_three_channel_c(pwm[0]),
		.pwm_three_channel_b(pwm[1]),
		.pwm_one_channel_c(pwm[2]),
		.pwm_one_channel_b(pwm[3]),
		.pwm_chan_en(pwm_en),
		.pwm_shutdown(pwm_sd),
		.analog_en(analog_en)
	);

	uph_pad_model i_uph_pad_model (
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.ext_drv(ext),
		.pin_in(pin_in)
	);

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask

	// Write then read with no gap, as read-modify-write code does
	task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		cmp(rd_data, e);
	endtask

	// Covers pin latency plus the two sync flops
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		cmp(d, e);
	endtask

	task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
		cmp(g, e);
	endtask

	task automatic print_verdict();
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk_pin(pin_oe, 8'h00);
		chk_pin({4'h0, analog_en}, 8'h0f);
		chk_rd(3'h0, 8'hff);
		chk_rd(3'h2, 8'h00);
		chk_rd(3'h3, 8'h00);
		chk_rd(3'h4, 8'h80);
		chk_rd(3'h6, 8'h00);
		chk_rd(3'h1, 8'h0c);
		for (int k = 0; k <= 4; k++) begin
			wr(3'h3, 8'(k));
			settle();
			chk_pin({4'h0, analog_en}, 8'(4'hf >> k));
		end
		wr(3'h3, 8'h00);
		wr(3'h0, 8'h7f);
		settle();
		chk_pin({4'h0, analog_en}, 8'h07);
		wr(3'h3, 8'hff);
		chk_rd(3'h3, 8'h3f);
		wr(3'h2, 8'h55);
		wr(3'h0, 8'h0f);
		settle();
		chk_pin(pin_oe, 8'hf0);
		chk_pin(pin_out & pin_oe, 8'h50);
		chk_rd(3'h2, 8'h55);
		chk_rd(3'h1, 8'h5c);
		wr(3'h1, 8'haa);
		chk_rd(3'h2, 8'haa);
		wr_rd(3'h2, 8'ha5, 8'ha5);
		@(posedge clk);
		pwm_en <= 4'hf;
		settle();
		chk_pin(pin_out & 8'hf0, 8'h10);
		wr(3'h4, 8'h81);
		settle();
		chk_pin(pin_out & 8'hf0, 8'ha0);
		wr(3'h4, 8'h80);
		@(posedge clk);
		pwm_sd <= 1'b1;
		settle();
		chk_pin(pin_oe, 8'hf0);
		wr(3'h4, 8'h82);
		settle();
		chk_pin(pin_oe, 8'h00);
		wr(3'h4, 8'h00);
		wr(3'h0, 8'hff);
		settle();
		chk_pin(pin_oe, 8'h0f);
		chk_pin(pin_out & 8'h0f, 8'h09);
		@(posedge clk);
		mem_hi <= 4'h6;
		settle();
		chk_pin(pin_out & 8'h0f, 8'h06);
		print_verdict();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
